// >>> sbcsr_host_model.sv
// host side of the register bus: one-cycle read and write strobes
// assumes the bank samples strobes on the rising core clock edge
`timescale 1ns/1ps
`default_nettype none
module sbcsr_host_model (
  input wire logic i_core_clk,
  input wire logic [15:0] i_reg_rdata,
  input wire logic i_reg_rvalid,
  output logic o_reg_wr,
  output logic o_reg_rd,
  output logic [7:0] o_reg_addr,
  output logic [7:0] o_reg_wdata
);
  initial begin
    o_reg_wr = 1'b0;
    o_reg_rd = 1'b0;
    o_reg_addr = 8'hff;
    o_reg_wdata = 8'hff;
  end

  // ----------------------------------------
  // bus cycles
  // ----------------------------------------
  // an idle bus shows the inverse of the last value, so stale data never looks valid
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_core_clk);
    o_reg_addr = a;
    o_reg_wdata = d;
    o_reg_wr = 1'b1;
    @(negedge i_core_clk);
    o_reg_wr = 1'b0;
    o_reg_addr = ~a;
    o_reg_wdata = ~d;
  endtask

  // the valid strobe stands for one cycle only, so it is taken with the data at the next falling edge
  task automatic rd_reg(input logic [7:0] a, output logic [15:0] d, output logic ok);
    @(negedge i_core_clk);
    o_reg_addr = a;
    o_reg_rd = 1'b1;
    @(negedge i_core_clk);
    o_reg_rd = 1'b0;
    o_reg_addr = ~a;
    ok = i_reg_rvalid;
    d = i_reg_rdata;
  endtask
endmodule
`default_nettype wire

// >>> sbcsr_pin_sync.sv
// three-stage synchroniser for one asynchronous pin
// assumes the pin is a slow level; output moves once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module sbcsr_pin_sync (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_clk_en,
  input wire logic i_pin,
  output logic o_level
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic agree;

  assign agree = (s2_q == s3_q);

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      o_level <= 1'b0;
    end else if (i_clk_en) begin
      s1_q <= i_pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (agree) begin
        o_level <= s3_q;
      end
    end
  end
endmodule
`default_nettype wire

// >>> sbcsr_pkg.sv
// share bus configuration and status register bank: constants and types
// assumes a 40 MHz core clock; used by the bank, while its pin synchroniser takes nothing from it
package sbcsr_pkg;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] ADDR_FLAGS0 = 8'h00;
  localparam logic [7:0] ADDR_FLAGS1 = 8'h01;
  localparam logic [7:0] ADDR_FLAGS2 = 8'h02;
  localparam logic [7:0] ADDR_FLT_CFG = 8'h0d;
  localparam logic [7:0] ADDR_IN_CUR = 8'h13;
  localparam logic [7:0] ADDR_IN_VOLT = 8'h14;
  localparam logic [7:0] ADDR_LOC_V = 8'h15;
  localparam logic [7:0] ADDR_LOAD_V = 8'h16;
  localparam logic [7:0] ADDR_OUT_V = 8'h17;
  localparam logic [7:0] ADDR_OUT_CUR = 8'h18;
  localparam logic [7:0] ADDR_OUT_PWR = 8'h19;
  localparam logic [7:0] ADDR_TEMP = 8'h1b;
  localparam logic [7:0] ADDR_SHARE_LVL = 8'h1d;
  localparam logic [7:0] ADDR_MOD = 8'h1e;
  localparam logic [7:0] ADDR_SHARE_CFG = 8'h29;
  localparam logic [7:0] ADDR_SHARE_LIM = 8'h2a;

  // ----------------------------------------
  // field positions and reset values
  // ----------------------------------------
  localparam int CFG_SEL_BIT = 3;
  localparam int CFG_BSTR_BIT = 4;
  localparam int CFG_GAIN_HI = 2;
  localparam int CFG_GAIN_LO = 0;
  localparam int LIM_DIFF_HI = 7;
  localparam int LIM_DIFF_LO = 4;
  localparam int LIM_DROP_HI = 3;
  localparam int LIM_DROP_LO = 0;
  localparam int FLT_TIME_BIT = 7;
  localparam int FLT_ACT_HI = 6;
  localparam int FLT_ACT_LO = 4;
  localparam int F2_SHARE_BIT = 5;
  localparam int F2_EXT_BIT = 0;
  localparam logic [7:0] RST_CFG = 8'h00;
  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic [15:0] RD_ZERO = 16'h0000;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int SHARE_DBNC_NS = 10000;
  localparam int DBNC_CYC_I = (SHARE_DBNC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [11:0] DBNC_LAST = 12'(DBNC_CYC_I - 1);
  localparam logic [11:0] CNT_ZERO = 12'h000;
  localparam logic [11:0] CNT_ONE = 12'h001;

  typedef enum logic [2:0] {
    SBCSR_S_IDLE = 3'b001,
    SBCSR_S_WAIT = 3'b010,
    SBCSR_S_FAULT = 3'b100
  } sbcsr_flt_state_t;

endpackage

// >>> sbcsr_regs.sv
// share bus configuration and live/latched status register bank
// assumes a serial management front end that turns host frames into
// single-cycle read and write strobes on the core clock
`timescale 1ns/1ps
`default_nettype none
module sbcsr_regs (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_clk_en,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [15:0] o_reg_rdata,
  output logic o_reg_rvalid,
  input wire logic i_latched_view,
  input wire logic i_latched_clear,
  input wire logic [7:0] i_flags0,
  input wire logic [7:0] i_flags1,
  input wire logic [7:0] i_flags2,
  input wire logic i_external_fault_input,
  input wire logic i_share_out_of_limit,
  input wire logic [15:0] i_primary_current_sense,
  input wire logic [15:0] i_secondary_current_sense,
  input wire logic i_adc_bitstream,
  input wire logic i_digital_share,
  input wire logic [15:0] i_input_current,
  input wire logic [15:0] i_input_voltage,
  input wire logic [15:0] i_input_power,
  input wire logic [15:0] i_local_voltage_sense,
  input wire logic [15:0] i_load_voltage_sense,
  input wire logic [15:0] i_output_voltage,
  input wire logic [15:0] i_output_current,
  input wire logic [15:0] i_output_power,
  input wire logic [7:0] i_temperature,
  input wire logic [7:0] i_share_bus_level,
  input wire logic [7:0] i_modulation,
  output logic [15:0] o_share_current,
  output logic o_share_output_pin,
  output logic o_share_sense_sel,
  output logic [2:0] o_share_gain,
  output logic [3:0] o_slave_match_diff,
  output logic [3:0] o_master_drop_lsbs,
  output logic o_share_fault_flag,
  output logic o_share_fault_event,
  output logic [2:0] o_share_fault_action,
  output logic [15:0] o_input_power
);

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  logic [7:0] cfg_q;
  logic [7:0] lim_q;
  logic [7:0] flt_q;
  logic wr_cfg;
  logic wr_lim;
  logic wr_flt;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a == b);
  endfunction

  assign wr_cfg = i_reg_wr && hit(i_reg_addr, sbcsr_pkg::ADDR_SHARE_CFG);
  assign wr_lim = i_reg_wr && hit(i_reg_addr, sbcsr_pkg::ADDR_SHARE_LIM);
  assign wr_flt = i_reg_wr && hit(i_reg_addr, sbcsr_pkg::ADDR_FLT_CFG);

  // writes to any other address, status included, fall away
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cfg_q <= sbcsr_pkg::RST_CFG;
      lim_q <= sbcsr_pkg::RST_CFG;
      flt_q <= sbcsr_pkg::RST_CFG;
    end else if (i_clk_en) begin
      if (wr_cfg) begin
        cfg_q <= i_reg_wdata;
      end
      if (wr_lim) begin
        lim_q <= i_reg_wdata;
      end
      if (wr_flt) begin
        flt_q <= i_reg_wdata;
      end
    end
  end

  assign o_share_sense_sel = cfg_q[sbcsr_pkg::CFG_SEL_BIT];
  assign o_share_gain = cfg_q[sbcsr_pkg::CFG_GAIN_HI:sbcsr_pkg::CFG_GAIN_LO];
  assign o_slave_match_diff = lim_q[sbcsr_pkg::LIM_DIFF_HI:sbcsr_pkg::LIM_DIFF_LO];
  assign o_master_drop_lsbs = lim_q[sbcsr_pkg::LIM_DROP_HI:sbcsr_pkg::LIM_DROP_LO];
  assign o_share_fault_action = flt_q[sbcsr_pkg::FLT_ACT_HI:sbcsr_pkg::FLT_ACT_LO];

  // ----------------------------------------
  // share source and pin selection
  // ----------------------------------------
  logic [15:0] share_cur_d;
  logic share_pin_d;

  assign share_cur_d = cfg_q[sbcsr_pkg::CFG_SEL_BIT] ? i_secondary_current_sense
                                                    : i_primary_current_sense;
  assign share_pin_d = cfg_q[sbcsr_pkg::CFG_BSTR_BIT] ? i_adc_bitstream : i_digital_share;

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_share_current <= sbcsr_pkg::RD_ZERO;
      o_share_output_pin <= 1'b0;
      o_input_power <= sbcsr_pkg::RD_ZERO;
    end else if (i_clk_en) begin
      o_share_current <= share_cur_d;
      o_share_output_pin <= share_pin_d;
      o_input_power <= i_input_power;
    end
  end

  // ----------------------------------------
  // share fault qualification
  // ----------------------------------------
  // timing bit low: flag follows the condition; high: it must hold for the debounce time
  sbcsr_pkg::sbcsr_flt_state_t st_q;
  sbcsr_pkg::sbcsr_flt_state_t st_d;
  logic [11:0] cnt_q;
  logic dbnc_mode;
  logic cnt_done;

  assign dbnc_mode = flt_q[sbcsr_pkg::FLT_TIME_BIT];
  assign cnt_done = (cnt_q == sbcsr_pkg::DBNC_LAST);

  always_comb begin
    st_d = st_q;
    case (st_q)
      sbcsr_pkg::SBCSR_S_IDLE: begin
        if (i_share_out_of_limit) begin
          st_d = dbnc_mode ? sbcsr_pkg::SBCSR_S_WAIT : sbcsr_pkg::SBCSR_S_FAULT;
        end
      end
      sbcsr_pkg::SBCSR_S_WAIT: begin
        if (!i_share_out_of_limit) begin
          st_d = sbcsr_pkg::SBCSR_S_IDLE;
        end else if (cnt_done) begin
          st_d = sbcsr_pkg::SBCSR_S_FAULT;
        end
      end
      sbcsr_pkg::SBCSR_S_FAULT: begin
        if (!i_share_out_of_limit) begin
          st_d = sbcsr_pkg::SBCSR_S_IDLE;
        end
      end
      default: st_d = sbcsr_pkg::SBCSR_S_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_q <= sbcsr_pkg::SBCSR_S_IDLE;
      cnt_q <= sbcsr_pkg::CNT_ZERO;
      o_share_fault_flag <= 1'b0;
      o_share_fault_event <= 1'b0;
    end else if (i_clk_en) begin
      st_q <= st_d;
      cnt_q <= (st_q == sbcsr_pkg::SBCSR_S_WAIT) ? cnt_q + sbcsr_pkg::CNT_ONE : sbcsr_pkg::CNT_ZERO;
      o_share_fault_flag <= (st_d == sbcsr_pkg::SBCSR_S_FAULT);
      o_share_fault_event <= (st_d == sbcsr_pkg::SBCSR_S_FAULT) && (st_q != sbcsr_pkg::SBCSR_S_FAULT);
    end
  end

  // ----------------------------------------
  // live and latched flags
  // ----------------------------------------
  logic ext_lvl;
  logic [7:0] live0_q;
  logic [7:0] live1_q;
  logic [7:0] live2_q;
  logic [7:0] live2_d;
  logic [7:0] lat0_q;
  logic [7:0] lat1_q;
  logic [7:0] lat2_q;

  sbcsr_pin_sync u_ext_sync (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .i_clk_en(i_clk_en),
    .i_pin(i_external_fault_input),
    .o_level(ext_lvl)
  );

  always_comb begin
    live2_d = i_flags2;
    live2_d[sbcsr_pkg::F2_SHARE_BIT] = o_share_fault_flag;
    live2_d[sbcsr_pkg::F2_EXT_BIT] = ext_lvl;
  end

  // the latch clear loses to a flag that is present in the same cycle
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      live0_q <= sbcsr_pkg::RST_FLAGS;
      live1_q <= sbcsr_pkg::RST_FLAGS;
      live2_q <= sbcsr_pkg::RST_FLAGS;
      lat0_q <= sbcsr_pkg::RST_FLAGS;
      lat1_q <= sbcsr_pkg::RST_FLAGS;
      lat2_q <= sbcsr_pkg::RST_FLAGS;
    end else if (i_clk_en) begin
      live0_q <= i_flags0;
      live1_q <= i_flags1;
      live2_q <= live2_d;
      lat0_q <= (i_latched_clear ? sbcsr_pkg::RST_FLAGS : lat0_q) | live0_q;
      lat1_q <= (i_latched_clear ? sbcsr_pkg::RST_FLAGS : lat1_q) | live1_q;
      lat2_q <= (i_latched_clear ? sbcsr_pkg::RST_FLAGS : lat2_q) | live2_q;
    end
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  logic [7:0] f0_v;
  logic [7:0] f1_v;
  logic [7:0] f2_v;
  logic [15:0] rd_mux;
  logic [7:0] a;

  assign a = i_reg_addr;
  assign f0_v = i_latched_view ? lat0_q : live0_q;
  assign f1_v = i_latched_view ? lat1_q : live1_q;
  assign f2_v = i_latched_view ? lat2_q : live2_q;

  // unmapped addresses read as zero; 8-bit registers sit in the low byte
  assign rd_mux =
    hit(a, sbcsr_pkg::ADDR_FLAGS0) ? {8'h00, f0_v} :
    hit(a, sbcsr_pkg::ADDR_FLAGS1) ? {8'h00, f1_v} :
    hit(a, sbcsr_pkg::ADDR_FLAGS2) ? {8'h00, f2_v} :
    hit(a, sbcsr_pkg::ADDR_FLT_CFG) ? {8'h00, flt_q} :
    hit(a, sbcsr_pkg::ADDR_IN_CUR) ? i_input_current :
    hit(a, sbcsr_pkg::ADDR_IN_VOLT) ? i_input_voltage :
    hit(a, sbcsr_pkg::ADDR_LOC_V) ? i_local_voltage_sense :
    hit(a, sbcsr_pkg::ADDR_LOAD_V) ? i_load_voltage_sense :
    hit(a, sbcsr_pkg::ADDR_OUT_V) ? i_output_voltage :
    hit(a, sbcsr_pkg::ADDR_OUT_CUR) ? i_output_current :
    hit(a, sbcsr_pkg::ADDR_OUT_PWR) ? i_output_power :
    hit(a, sbcsr_pkg::ADDR_TEMP) ? {8'h00, i_temperature} :
    hit(a, sbcsr_pkg::ADDR_SHARE_LVL) ? {8'h00, i_share_bus_level} :
    hit(a, sbcsr_pkg::ADDR_MOD) ? {8'h00, i_modulation} :
    hit(a, sbcsr_pkg::ADDR_SHARE_CFG) ? {8'h00, cfg_q} :
    hit(a, sbcsr_pkg::ADDR_SHARE_LIM) ? {8'h00, lim_q} :
    sbcsr_pkg::RD_ZERO;

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_reg_rdata <= sbcsr_pkg::RD_ZERO;
      o_reg_rvalid <= 1'b0;
    end else if (i_clk_en) begin
      o_reg_rvalid <= i_reg_rd;
      if (i_reg_rd) begin
        o_reg_rdata <= rd_mux;
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_resetn);

  sense_sel_a: assert property (i_clk_en && wr_cfg |=>
    o_share_sense_sel == $past(i_reg_wdata[3]) ##1
    (!i_clk_en || o_share_current == ($past(o_share_sense_sel) ?
      $past(i_secondary_current_sense) : $past(i_primary_current_sense))))
    else $error("share current source does not follow select bit");
  pin_mux_a: assert property (i_clk_en |=>
    o_share_output_pin == ($past(cfg_q[4]) ? $past(i_adc_bitstream) : $past(i_digital_share)))
    else $error("share pin source wrong");
  gain_field_a: assert property (i_clk_en && wr_cfg |=> o_share_gain == $past(i_reg_wdata[2:0]))
    else $error("gain field not written");
  match_diff_a: assert property (i_clk_en && wr_lim |=> o_slave_match_diff == $past(i_reg_wdata[7:4]))
    else $error("match difference field not written");
  drop_lsbs_a: assert property (i_clk_en && wr_lim |=> o_master_drop_lsbs == $past(i_reg_wdata[3:0]))
    else $error("drop field not written");
  fault_immed_a: assert property (i_clk_en && st_q == sbcsr_pkg::SBCSR_S_IDLE &&
    i_share_out_of_limit && !dbnc_mode |=> o_share_fault_flag)
    else $error("immediate share fault not flagged");
  fault_dbnc_a: assert property (i_clk_en && st_q == sbcsr_pkg::SBCSR_S_IDLE &&
    i_share_out_of_limit && dbnc_mode |=> !o_share_fault_flag [*2])
    else $error("debounced share fault flagged too early");
  fault_action_a: assert property (i_clk_en && wr_flt |=> o_share_fault_action == $past(i_reg_wdata[6:4]))
    else $error("fault action field not written");
  tele_read_a: assert property (i_clk_en && i_reg_rd && a == sbcsr_pkg::ADDR_OUT_PWR |=>
    o_reg_rvalid && o_reg_rdata == $past(i_output_power))
    else $error("telemetry read mismatch");
  byte_read_a: assert property (i_clk_en && i_reg_rd && a == sbcsr_pkg::ADDR_TEMP |=>
    o_reg_rdata == {8'h00, $past(i_temperature)})
    else $error("temperature read mismatch");
  live_zero_a: assert property (i_clk_en |=> live0_q == $past(i_flags0))
    else $error("live flags 0 stale");
  live_one_a: assert property (i_clk_en |=> live1_q == $past(i_flags1))
    else $error("live flags 1 stale");
  live_two_a: assert property (i_clk_en |=> live2_q[4] == $past(i_flags2[4]) &&
    live2_q[5] == $past(o_share_fault_flag) && live2_q[0] == $past(ext_lvl))
    else $error("live flags 2 stale");
  latch_hold_a: assert property (i_clk_en && live1_q != 8'h00 |=> (lat1_q & $past(live1_q)) == $past(live1_q))
    else $error("latched flag lost");
  no_write_a: assert property (i_clk_en && i_reg_wr && a == sbcsr_pkg::ADDR_FLAGS0 |=>
    live0_q == $past(i_flags0))
    else $error("host write altered live flags");

  cfg_write_c: cover property (i_clk_en && wr_cfg);
  fault_enter_c: cover property (o_share_fault_event);
  latched_read_c: cover property (i_clk_en && i_reg_rd && i_latched_view && lat2_q != 8'h00);
  dbnc_abort_c: cover property (st_q == sbcsr_pkg::SBCSR_S_WAIT && !i_share_out_of_limit);

endmodule
`default_nettype wire

// >>> sbcsr_regs_tb.sv
// self-checking bench for the share bus register bank
// assumes the host model drives the register bus; all inputs change on falling edges
`timescale 1ns/1ps
`default_nettype none
module sbcsr_regs_tb;
  typedef struct packed {logic [7:0] addr; logic [15:0] exp;} sbcsr_row_t;
  logic clk, rstn, clk_en, lat_view, lat_clr, ext_in, cond, adc_bs, dig_sh;
  logic wr, rd, rvalid, pin, sel, fflag, fevent;
  logic [7:0] addr, wdata, f0, f1, f2;
  logic [15:0] rdata, share_cur, inpwr;
  logic [2:0] gain, fact;
  logic [3:0] diff, drop;
  logic [15:0] rd_d;
  logic rd_ok;
  logic [15:0] cs1, cs2, tele_icur, tele_ivolt, tele_ipwr, tele_locv, tele_loadv, tele_outv, tele_ocur, tele_opwr;
  logic [7:0] tele_temp, tele_lvl, tele_mod;
  int n_errors = 0;
  int checks_done = 0;
  int cyc, ev;
  sbcsr_row_t rows [19] = '{
    '{8'h13, 16'h13c1}, '{8'h14, 16'h14c2}, '{8'h15, 16'h15c3}, '{8'h16, 16'h16c4},
    '{8'h17, 16'h17c5}, '{8'h18, 16'h18c6}, '{8'h19, 16'h19c7}, '{8'h1b, 16'h003b},
    '{8'h1d, 16'h003d}, '{8'h1e, 16'h003e}, '{8'h00, 16'h00a5}, '{8'h01, 16'h005a},
    '{8'h02, 16'h00de}, '{8'h0d, 16'h005b}, '{8'h29, 16'h001d}, '{8'h2a, 16'h00a5},
    '{8'h03, 16'h0000}, '{8'h1a, 16'h0000}, '{8'h2b, 16'h0000}};

  sbcsr_host_model host_u (.i_core_clk(clk), .i_reg_rdata(rdata), .i_reg_rvalid(rvalid),
    .o_reg_wr(wr), .o_reg_rd(rd), .o_reg_addr(addr), .o_reg_wdata(wdata));

  sbcsr_regs dut_u (.i_core_clk(clk), .i_resetn(rstn), .i_clk_en(clk_en), .i_reg_wr(wr),
    .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .o_reg_rvalid(rvalid), .i_latched_view(lat_view), .i_latched_clear(lat_clr),
    .i_flags0(f0), .i_flags1(f1), .i_flags2(f2), .i_external_fault_input(ext_in),
    .i_share_out_of_limit(cond), .i_primary_current_sense(cs1),
    .i_secondary_current_sense(cs2), .i_adc_bitstream(adc_bs), .i_digital_share(dig_sh),
    .i_input_current(tele_icur), .i_input_voltage(tele_ivolt), .i_input_power(tele_ipwr),
    .i_local_voltage_sense(tele_locv), .i_load_voltage_sense(tele_loadv),
    .i_output_voltage(tele_outv), .i_output_current(tele_ocur), .i_output_power(tele_opwr),
    .i_temperature(tele_temp), .i_share_bus_level(tele_lvl), .i_modulation(tele_mod),
    .o_share_current(share_cur), .o_share_output_pin(pin), .o_share_sense_sel(sel),
    .o_share_gain(gain), .o_slave_match_diff(diff), .o_master_drop_lsbs(drop),
    .o_share_fault_flag(fflag), .o_share_fault_event(fevent), .o_share_fault_action(fact),
    .o_input_power(inpwr));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    host_u.rd_reg(a, rd_d, rd_ok);
    check({15'h0000, rd_ok}, 16'h0001);
    check(rd_d, exp);
  endtask

  // bounded wait for the share fault flag, counting event pulses on the way
  task automatic wait_flag();
    cyc = 0;
    ev = 0;
    while (fflag !== 1'b1 && cyc < 600) begin
      @(negedge clk);
      cyc++;
      if (fevent === 1'b1) ev++;
    end
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // clock, watchdog
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    conclude();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rstn = 1'b0;
    clk_en = 1'b1;
    {lat_view, lat_clr, ext_in, cond, dig_sh} = 5'h00;
    adc_bs = 1'b1;
    f0 = 8'ha5;
    f1 = 8'h5a;
    f2 = 8'hde;
    {cs1, cs2} = {16'h0c51, 16'h0c52};
    {tele_icur, tele_ivolt, tele_ipwr, tele_locv} = {16'h13c1, 16'h14c2, 16'h2bad, 16'h15c3};
    {tele_loadv, tele_outv, tele_ocur, tele_opwr} = {16'h16c4, 16'h17c5, 16'h18c6, 16'h19c7};
    {tele_temp, tele_lvl, tele_mod} = {8'h3b, 8'h3d, 8'h3e};
    repeat (6) @(negedge clk);
    rstn = 1'b1;
    rd_chk(8'h29, 16'h0000);
    host_u.wr_reg(8'h29, 8'h1d);
    host_u.wr_reg(8'h2a, 8'ha5);
    host_u.wr_reg(8'h0d, 8'h5b);
    repeat (2) @(negedge clk);
    check({15'h0000, sel}, 16'h0001);
    check(share_cur, 16'h0c52);
    check({15'h0000, pin}, 16'h0001);
    check({13'h0000, gain}, 16'h0005);
    check({12'h000, diff}, 16'h000a);
    check({12'h000, drop}, 16'h0005);
    check({13'h0000, fact}, 16'h0005);
    check(inpwr, 16'h2bad);
    for (int i = 0; i < 19; i++) begin
      rd_chk(rows[i].addr, rows[i].exp);
    end
    // walk one flag at a time; bits 5 and 0 of the third register have their own sources
    for (int b = 0; b < 8; b++) begin
      f0 = 8'(1 << b);
      f1 = 8'(8'h80 >> b);
      f2 = 8'(1 << b) & 8'hde;
      rd_chk(8'h00, {8'h00, f0});
      rd_chk(8'h01, {8'h00, f1});
      rd_chk(8'h02, {8'h00, f2});
    end
    host_u.wr_reg(8'h00, 8'hff);
    host_u.wr_reg(8'h02, 8'hff);
    rd_chk(8'h00, {8'h00, f0});
    rd_chk(8'h02, {8'h00, f2});
    host_u.wr_reg(8'h29, 8'h02);
    repeat (2) @(negedge clk);
    check({15'h0000, sel}, 16'h0000);
    check(share_cur, 16'h0c51);
    check({15'h0000, pin}, 16'h0000);
    check({13'h0000, gain}, 16'h0002);
    // readings are live values, so a change must show on the next read
    cs1 = 16'h1c50;
    tele_ipwr = 16'h4d2b;
    tele_opwr = 16'h7e19;
    tele_temp = 8'h4c;
    rd_chk(8'h19, 16'h7e19);
    rd_chk(8'h1b, 16'h004c);
    check(inpwr, 16'h4d2b);
    check(share_cur, 16'h1c50);
    cond = 1'b1;
    wait_flag();
    check(16'(cyc >= 1 && cyc <= 2), 16'h0001);
    check(16'(ev), 16'h0001);
    rd_chk(8'h02, {8'h00, f2 | 8'h20});
    cond = 1'b0;
    repeat (3) @(negedge clk);
    check({15'h0000, fflag}, 16'h0000);
    host_u.wr_reg(8'h0d, 8'hdb);
    // a drop in mid-debounce must restart the count
    cond = 1'b1;
    repeat (200) @(negedge clk);
    cond = 1'b0;
    @(negedge clk);
    cond = 1'b1;
    wait_flag();
    check(16'(cyc >= 399 && cyc <= 405), 16'h0001);
    check(16'(ev), 16'h0001);
    check({13'h0000, fact}, 16'h0005);
    cond = 1'b0;
    ext_in = 1'b1;
    repeat (6) @(negedge clk);
    rd_chk(8'h02, {8'h00, f2 | 8'h01});
    ext_in = 1'b0;
    f0 = 8'h00;
    // a flag still live at the clear is kept, so the live register empties first
    @(negedge clk);
    lat_clr = 1'b1;
    @(negedge clk);
    lat_clr = 1'b0;
    f0 = 8'h04;
    repeat (2) @(negedge clk);
    f0 = 8'h00;
    repeat (3) @(negedge clk);
    lat_view = 1'b1;
    rd_chk(8'h00, 16'h0004);
    lat_view = 1'b0;
    rd_chk(8'h00, 16'h0000);
    lat_clr = 1'b1;
    @(negedge clk);
    lat_clr = 1'b0;
    lat_view = 1'b1;
    rd_chk(8'h00, 16'h0000);
    lat_view = 1'b0;
    // nothing is taken while the clock enable is low
    clk_en = 1'b0;
    host_u.wr_reg(8'h2a, 8'h00);
    clk_en = 1'b1;
    rd_chk(8'h2a, 16'h00a5);
    // a reset in mid-run brings the configuration back to zero
    rstn = 1'b0;
    @(negedge clk);
    check({8'h00, diff, drop}, 16'h0000);
    check({13'h0000, fact}, 16'h0000);
    check({15'h0000, fflag}, 16'h0000);
    rstn = 1'b1;
    rd_chk(8'h29, 16'h0000);
    rd_chk(8'h2a, 16'h0000);
    conclude();
  end
endmodule
`default_nettype wire
